/* File: core/lbls_pkg.sv */
/*
 * constants, types and the byte-enable decoder shared by the load/store
 * byte lane steering core and its steering datapath.
 * assumes a big-endian 32-bit data bus numbered with bit 0 as msb.
 */
`default_nettype none

package lbls_pkg;

    // ************************************************************
    // access sizes and addressed device widths
    // ************************************************************
    localparam logic [1:0] LBLS_SZ_BYTE = 2'h0;
    localparam logic [1:0] LBLS_SZ_HALF = 2'h1;
    localparam logic [1:0] LBLS_SZ_WORD = 2'h2;
    // device widths share the size codes so they compare directly
    localparam logic [1:0] LBLS_DEV_8 = 2'h0;
    localparam logic [1:0] LBLS_DEV_16 = 2'h1;
    localparam logic [1:0] LBLS_DEV_32 = 2'h2;

    // ************************************************************
    // byte enable patterns, bit 0 is the msb lane
    // ************************************************************
    localparam logic [0:3] LBLS_BE_NONE = 4'h0;
    localparam logic [0:3] LBLS_BE_B3 = 4'h1;
    localparam logic [0:3] LBLS_BE_B2 = 4'h2;
    localparam logic [0:3] LBLS_BE_B1 = 4'h4;
    localparam logic [0:3] LBLS_BE_B0 = 4'h8;
    localparam logic [0:3] LBLS_BE_H1 = 4'h3;
    localparam logic [0:3] LBLS_BE_H0 = 4'hc;
    localparam logic [0:3] LBLS_BE_W = 4'hf;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [0:31] LBLS_RST_WORD = 32'h0;

    typedef enum logic [1:0] {
        LBLS_IDLE = 2'b01,
        LBLS_BUSY = 2'b10
    } lbls_state_t;

    // enables from size and address bits [30:31]; misaligned gives none
    function automatic logic [0:3] lbls_be(input logic [1:0] size,
                                           input logic [1:0] lo);
        logic [0:3] be;
        be = LBLS_BE_NONE;
        case (size)
            LBLS_SZ_BYTE: begin
                case (lo)
                    2'h3: be = LBLS_BE_B3;
                    2'h2: be = LBLS_BE_B2;
                    2'h1: be = LBLS_BE_B1;
                    default: be = LBLS_BE_B0;
                endcase
            end
            LBLS_SZ_HALF: begin
                if (lo == 2'h2) begin
                    be = LBLS_BE_H1;
                end else if (lo == 2'h0) begin
                    be = LBLS_BE_H0;
                end
            end
            LBLS_SZ_WORD: begin
                if (lo == 2'h0) begin
                    be = LBLS_BE_W;
                end
            end
            default: be = LBLS_BE_NONE;
        endcase
        return be;
    endfunction

endpackage

`default_nettype wire

/* File: core/lbls_steer.sv */
/*
 * combinational lane steering: byte enables, write lane placement and
 * read data right-justification with zero fill.
 * assumes size and low address come from the same access as the data.
 */
`timescale 1ns/1ps
`default_nettype none

module lbls_steer
    import lbls_pkg::*;
(
    input wire logic [1:0] size,
    input wire logic [1:0] lo,
    input wire logic [0:31] reg_data,
    input wire logic [0:31] bus_data,
    output logic [0:3] be,
    output logic [0:31] lanes_out,
    output logic [0:31] reg_out
);

    // ************************************************************
    // first register byte used by the item: byte 3, half 2, word 0
    // ************************************************************
    logic [1:0] first;

    assign be = lbls_be(size, lo);
    assign first = (size == LBLS_SZ_BYTE) ? 2'h3 :
                   (size == LBLS_SZ_HALF) ? 2'h2 : 2'h0;

    // ************************************************************
    // per-lane placement; msb of the item goes to the lowest lane
    // ************************************************************
    for (genvar i = 0; i < 4; i++) begin : g_lane
        logic [1:0] rb;
        logic [1:0] ln;
        // register byte feeding lane i, wraps harmlessly when unused
        assign rb = 2'(first + 2'(i) - lo);
        // bus lane feeding register byte i
        assign ln = 2'(2'(i) - first + lo);
        // unused lanes driven to zero so stray data never leaks
        assign lanes_out[8*i +: 8] = be[i] ? reg_data[8*rb +: 8] : 8'h0;
        // bytes above the item are cleared on narrow loads
        assign reg_out[8*i +: 8] = (2'(i) >= first) ?
                                   bus_data[8*ln +: 8] : 8'h0;
    end

endmodule

`default_nettype wire

/* File: core/lbls_core.sv */
/*
 * data-side load/store byte lane steering core with a local memory bus
 * master port.
 * assumes slaves share CLK, answer with DREADY, and that narrow slaves
 * are wired to the most significant lanes.
 */
// Notes on behaviour
// RULE1 - steer byte/half/word to 32-bit, byte/half to 16-bit, byte to 8-bit
// RULE2 - never access wider than the device; no bus sizing sequences
// RULE3 - byte load enables by address 11/10/01/00; byte lands in bits 24-31
// RULE4 - half load at 10: enables 0011, lanes 2,3 to bits 16-31
// RULE5 - half load at 00: enables 1100, lanes 0,1 to bits 16-31
// RULE6 - word load at 00: enables 1111, lanes copied straight across
// RULE7 - byte store: bits 24-31 on the addressed lane, same enables
// RULE8 - half store at 10: enables 0011, bits 16-31 on lanes 2,3
// RULE9 - half store at 00: enables 1100, bits 16-31 on lanes 0,1
// RULE10 - word store: enables 1111, bits 0-31 onto lanes 0-3
// RULE11 - narrow slaves sit left-justified; steering ignores the device width and uses the lanes set by address bits 30-31
// RULE12 - bit 0 is the msb on every bus and register
// RULE13 - big-endian: most significant byte at lowest address
// RULE14 - only word, half and byte items; word spans n to n+3
// RULE15 - operands and register contents are kept big-endian
// RULE16 - little-endian memories need byte and address bit reversal
// RULE17 - a single byte is the same under either byte order
// RULE18 - slaves read enables only while the start strobe is high
// RULE19 - only enabled lanes carry store data; slaves write only those
// RULE20 - bytes not loaded by a narrow load read as zero
`timescale 1ns/1ps
`default_nettype none

module lbls_core
    import lbls_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [1:0] REQ_DEV,
    input wire logic [0:31] REQ_ADDR,
    input wire logic [0:31] REQ_WDATA,
    output logic REQ_READY,
    output logic DONE,
    output logic ACCESS_ERR,
    output logic [0:31] LOAD_DATA,
    output logic [0:31] DATA_ADDR,
    output logic [0:3] BYTE_EN,
    output logic [0:31] DATA_WRITE,
    output logic TRANSFER_START_STROBE,
    output logic READ_STROBE,
    output logic WRITE_STROBE,
    input wire logic [0:31] DATA_READ,
    input wire logic DREADY
);

    // ************************************************************
    // state
    // ************************************************************
    lbls_state_t state_r, state_nxt;
    logic ready_r, done_r, err_r, as_r, rd_r, wr_r;
    logic [0:31] addr_r, wdata_r, load_r;
    logic [0:3] be_r;
    logic [1:0] size_r, dev_r;

    // ************************************************************
    // steering of the incoming request and of the returning data
    // ************************************************************
    logic [0:3] req_be;
    logic [0:31] req_lanes, load_steered;
    logic req_take, req_legal, fits, finish;

    // request side: enables and write lane placement [RULE7] [RULE9]
    lbls_steer u_req_steer (
        .size(REQ_SIZE),
        .lo(REQ_ADDR[30:31]),
        .reg_data(REQ_WDATA),
        .bus_data(LBLS_RST_WORD),
        .be(req_be),
        .lanes_out(req_lanes),
        .reg_out()
    );

    // load side uses the size and address held for the transfer [RULE20]
    // a lone byte takes the same lane under either byte order [RULE17]
    lbls_steer u_load_steer (
        .size(size_r),
        .lo(addr_r[30:31]),
        .reg_data(LBLS_RST_WORD),
        .bus_data(DATA_READ),
        .be(),
        .lanes_out(),
        .reg_out(load_steered)
    );

    // accept only aligned items no wider than the device [RULE1] [RULE2]
    // misaligned or unknown sizes decode to no enables [RULE14]
    assign fits = (REQ_SIZE <= REQ_DEV) && (REQ_DEV <= LBLS_DEV_32);
    assign req_legal = fits && (req_be != LBLS_BE_NONE);
    assign req_take = REQ_VALID && ready_r;
    assign finish = (state_r == LBLS_BUSY) && DREADY;

    // ************************************************************
    // transfer sequencing
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LBLS_IDLE: begin
                if (req_take && req_legal) begin
                    state_nxt = LBLS_BUSY;
                end
            end
            LBLS_BUSY: begin
                if (DREADY) begin
                    state_nxt = LBLS_IDLE;
                end
            end
            default: state_nxt = LBLS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= LBLS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // strobes: start strobe one cycle, read/write strobe until ready
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            as_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            as_r <= (state_r == LBLS_IDLE) && req_take && req_legal;
            rd_r <= (req_take && req_legal && !REQ_WRITE) ||
                    (rd_r && !finish);
            wr_r <= (req_take && req_legal && REQ_WRITE) ||
                    (wr_r && !finish);
            ready_r <= (state_nxt == LBLS_IDLE) && !(req_take && req_legal);
            done_r <= finish;
            err_r <= req_take && !req_legal;
        end
    end

    // transfer image held for the whole access; enables only valid with
    // the start strobe, but holding them is harmless [RULE18]
    // the lanes outside the enables carry zero [RULE19]
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_r <= LBLS_RST_WORD;
            wdata_r <= LBLS_RST_WORD;
            be_r <= LBLS_BE_NONE;
            size_r <= LBLS_SZ_BYTE;
            dev_r <= LBLS_DEV_8;
        end else if (req_take && req_legal) begin
            addr_r <= REQ_ADDR;
            wdata_r <= REQ_WRITE ? req_lanes : LBLS_RST_WORD; // [RULE10]
            be_r <= req_be;                                   // [RULE3]
            size_r <= REQ_SIZE;
            dev_r <= REQ_DEV;
        end
    end

    // load capture; data stays big-endian, bit 0 msb [RULE15] [RULE12]
    // msb of the item comes from the lowest addressed lane [RULE13]
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            load_r <= LBLS_RST_WORD;
        end else if (finish && rd_r) begin
            load_r <= load_steered; // [RULE4] [RULE5] [RULE6]
        end
    end

    // ************************************************************
    // outputs, all straight from flip-flops
    // ************************************************************
    assign REQ_READY = ready_r;
    assign DONE = done_r;
    assign ACCESS_ERR = err_r;
    assign LOAD_DATA = load_r;
    assign DATA_ADDR = addr_r;
    assign BYTE_EN = be_r;
    assign DATA_WRITE = wdata_r;
    assign TRANSFER_START_STROBE = as_r;
    assign READ_STROBE = rd_r;
    assign WRITE_STROBE = wr_r;

    // ************************************************************
    // checks
    // ************************************************************
    property p_no_wide;
        @(posedge CLK) disable iff (!RESETN)
        as_r |-> (size_r <= dev_r);
    endproperty
    a_no_wide: assert property (p_no_wide) // [RULE2]
        else $error("access wider than device");

    property p_byte_be;
        @(posedge CLK) disable iff (!RESETN)
        (as_r && size_r == LBLS_SZ_BYTE) |->
            (be_r == (LBLS_BE_B0 >> addr_r[30:31]));
    endproperty
    a_byte_be: assert property (p_byte_be) // [RULE3]
        else $error("byte enable does not match address");

    property p_half_be;
        @(posedge CLK) disable iff (!RESETN)
        (as_r && size_r == LBLS_SZ_HALF) |->
            (be_r == (addr_r[30] ? LBLS_BE_H1 : LBLS_BE_H0));
    endproperty
    a_half_be: assert property (p_half_be) // [RULE4]
        else $error("halfword enables wrong");

    property p_word_store;
        @(posedge CLK) disable iff (!RESETN)
        (req_take && req_legal && REQ_WRITE && REQ_SIZE == LBLS_SZ_WORD)
            |=> (DATA_WRITE == $past(REQ_WDATA)) && (BYTE_EN == LBLS_BE_W);
    endproperty
    a_word_store: assert property (p_word_store) // [RULE10]
        else $error("word store lanes wrong");

    property p_byte_store;
        @(posedge CLK) disable iff (!RESETN)
        (req_take && req_legal && REQ_WRITE && REQ_SIZE == LBLS_SZ_BYTE
            && REQ_ADDR[30:31] == 2'h0)
            |=> (DATA_WRITE[0:7] == $past(REQ_WDATA[24:31]))
                && (DATA_WRITE[8:31] == 24'h0);
    endproperty
    a_byte_store: assert property (p_byte_store) // [RULE7]
        else $error("byte store not on lane 0");

    property p_half_store;
        @(posedge CLK) disable iff (!RESETN)
        (req_take && req_legal && REQ_WRITE && REQ_SIZE == LBLS_SZ_HALF
            && REQ_ADDR[30:31] == 2'h2)
            |=> (DATA_WRITE[16:31] == $past(REQ_WDATA[16:31]))
                && (BYTE_EN == LBLS_BE_H1);
    endproperty
    a_half_store: assert property (p_half_store) // [RULE8]
        else $error("halfword store lanes wrong");

    property p_half_store_lo;
        @(posedge CLK) disable iff (!RESETN)
        (req_take && req_legal && REQ_WRITE && REQ_SIZE == LBLS_SZ_HALF
            && REQ_ADDR[30:31] == 2'h0)
            |=> (DATA_WRITE == {$past(REQ_WDATA[16:31]), 16'h0})
                && (BYTE_EN == LBLS_BE_H0);
    endproperty
    a_half_store_lo: assert property (p_half_store_lo) // [RULE9]
        else $error("halfword store to lanes 0 and 1 wrong");

    property p_byte_load;
        @(posedge CLK) disable iff (!RESETN)
        (finish && rd_r && size_r == LBLS_SZ_BYTE && addr_r[30:31] == 2'h1)
            |=> (LOAD_DATA == {24'h0, $past(DATA_READ[8:15])});
    endproperty
    a_byte_load: assert property (p_byte_load) // [RULE20]
        else $error("byte load not right-justified with zero fill");

    property p_half_load;
        @(posedge CLK) disable iff (!RESETN)
        (finish && rd_r && size_r == LBLS_SZ_HALF && addr_r[30:31] == 2'h0)
            |=> (LOAD_DATA == {16'h0, $past(DATA_READ[0:15])});
    endproperty
    a_half_load: assert property (p_half_load) // [RULE5]
        else $error("halfword load from lanes 0 and 1 wrong");

    property p_word_load;
        @(posedge CLK) disable iff (!RESETN)
        (finish && rd_r && size_r == LBLS_SZ_WORD)
            |=> (LOAD_DATA == $past(DATA_READ));
    endproperty
    a_word_load: assert property (p_word_load) // [RULE6]
        else $error("word load not copied straight");

    property p_refuse;
        @(posedge CLK) disable iff (!RESETN)
        (req_take && !req_legal) |=> ACCESS_ERR && !TRANSFER_START_STROBE
            ##1 REQ_READY;
    endproperty
    a_refuse: assert property (p_refuse) // [RULE1]
        else $error("illegal access not refused");

    c_load: cover property (@(posedge CLK) disable iff (!RESETN)
        as_r && rd_r ##[1:4] DONE);
    c_store: cover property (@(posedge CLK) disable iff (!RESETN)
        as_r && wr_r ##[1:4] DONE);
    c_err: cover property (@(posedge CLK) disable iff (!RESETN) ACCESS_ERR);
    c_wait: cover property (@(posedge CLK) disable iff (!RESETN)
        as_r && !DREADY ##1 !DREADY ##1 DREADY);

endmodule

`default_nettype wire

/* File: tb/lbls_slave_model.sv */
/* slave model: 16-word memory on the data bus with set wait states.
   assumes lbls_core drives the bus on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module lbls_slave_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [0:31] addr, // bit 0 is the msb
    input wire logic [0:3] be,
    input wire logic [0:31] wdata,
    input wire logic start,
    input wire logic wr,
    input wire logic [3:0] wait_n,
    output logic [0:31] rdata,
    output logic ready
);
    // store numbered little-endian; ports stay big-endian
    logic [31:0] mem [16];
    logic [0:31] a_r;
    logic [3:0] idx;
    logic [0:3] be_r;
    logic w_r;
    logic busy_r;
    logic [3:0] cnt_r;
    // ********
    // memory, lane 0 is the most significant byte
    // ********
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h0;
        end
    end
    // positional copy reverses the address bit order
    assign idx = a_r[26:29];
    // idle read bus toggles so stale data is never mistaken for valid
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            ready <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ready <= 1'b0;
            rdata <= ~rdata;
            if (start) begin // enables read only with the strobe
                busy_r <= 1'b1;
                a_r <= addr;
                be_r <= be;
                w_r <= wr;
                cnt_r <= wait_n;
            end else if (busy_r && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                ready <= 1'b1;
                rdata <= mem[idx]; // bit order reversed by position
                for (int l = 0; l < 4; l++) begin
                    if (w_r && be_r[l]) begin // enabled lanes only
                        mem[idx][(3 - l) * 8 +: 8] <= wdata[l * 8 +: 8];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/lbls_core_tb_top.sv */
/* bench for lbls_core: each scenario task issues accesses and judges results.
   assumes lbls_slave_model answers on the data bus side. */
`timescale 1ns/1ps
`default_nettype none
module lbls_core_tb_top;
    import lbls_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic REQ_VALID = 1'b0;
    logic REQ_WRITE = 1'b0;
    logic [1:0] REQ_SIZE = 2'h0;
    logic [1:0] REQ_DEV = 2'h0;
    logic [0:31] REQ_ADDR = 32'h0;
    logic [0:31] REQ_WDATA = 32'h0;
    logic [3:0] wait_n = 4'h0;
    logic [0:31] LOAD_DATA, DATA_ADDR, DATA_WRITE, DATA_READ, got_v;
    logic REQ_READY, DONE, ACCESS_ERR, TRANSFER_START_STROBE, DREADY;
    logic READ_STROBE, WRITE_STROBE;
    logic [0:3] BYTE_EN, got_be;
    int num_errors = 0;
    int tests_run = 0;

    lbls_core dut_u (.CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
        .REQ_WRITE(REQ_WRITE), .REQ_SIZE(REQ_SIZE), .REQ_DEV(REQ_DEV),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
        .DONE(DONE), .ACCESS_ERR(ACCESS_ERR), .LOAD_DATA(LOAD_DATA),
        .DATA_ADDR(DATA_ADDR), .BYTE_EN(BYTE_EN), .DATA_WRITE(DATA_WRITE),
        .TRANSFER_START_STROBE(TRANSFER_START_STROBE),
        .READ_STROBE(READ_STROBE), .WRITE_STROBE(WRITE_STROBE),
        .DATA_READ(DATA_READ), .DREADY(DREADY));
    lbls_slave_model slave_u (.clk(CLK), .resetn(RESETN),
        .addr(DATA_ADDR), .be(BYTE_EN), .wdata(DATA_WRITE),
        .start(TRANSFER_START_STROBE), .wr(WRITE_STROBE),
        .wait_n(wait_n), .rdata(DATA_READ), .ready(DREADY));

    // 50 MHz core clock
    always #10 CLK = ~CLK;

    // ********
    // shared tasks
    // ********
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [0:31] got, exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask

    // one request; bounded wait for the done or refusal pulse
    task automatic acc(input logic wr, input logic [1:0] sz, dv,
                       input logic [0:31] ad, wd, input logic x_err);
        int n;
        int st;
        logic e;
        logic rw;
        logic rdy;
        n = 0;
        st = 0;
        e = 1'b0;
        rw = 1'b0;
        rdy = 1'b0;
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= wr;
        REQ_SIZE <= sz;
        REQ_DEV <= dv;
        REQ_ADDR <= ad;
        REQ_WDATA <= wd;
        // hold the request until an edge samples ready high
        @(posedge CLK);
        while (REQ_READY !== 1'b1 && n < 40) begin
            @(posedge CLK);
            n++;
        end
        REQ_VALID <= 1'b0;
        while (n < 40 && DONE !== 1'b1 && e !== 1'b1) begin
            @(negedge CLK);
            n++;
            if (TRANSFER_START_STROBE === 1'b1) begin
                st++;
                rw = wr ? WRITE_STROBE : READ_STROBE;
                rdy = REQ_READY;
            end
            e = ACCESS_ERR;
        end
        if (n == 40) begin
            num_errors++;
            finish_test();
        end
        check("refused", 32'(e), 32'(x_err));
        check("starts", 32'(st), x_err ? 32'h0 : 32'h1);
        check("strobe", 32'(rw), 32'(!x_err));
        check("busy rdy", 32'(rdy), 32'h0);
        check("rdy", 32'(REQ_READY), 32'h1);
        if (!x_err) begin
            check("addr", DATA_ADDR, ad);
        end
        got_be = BYTE_EN;
        got_v = wr ? DATA_WRITE : LOAD_DATA;
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_word();
        acc(1, LBLS_SZ_WORD, LBLS_DEV_32, 32'h10, 32'h11121314, 0);
        check("st be", 32'(got_be), 32'hf);
        check("st data", got_v, 32'h11121314);
        acc(0, LBLS_SZ_WORD, LBLS_DEV_32, 32'h10, 32'h0, 0);
        check("ld be", 32'(got_be), 32'hf);
        check("ld word", got_v, 32'h11121314);
        $display("word test done");
    endtask

    // slow slave; every byte offset, upper bytes must clear
    task automatic t_narrow_ld();
        logic [7:0] b;
        wait_n <= 4'h2;
        for (int o = 0; o < 4; o++) begin
            b = 8'h11 + 8'(o);
            acc(0, LBLS_SZ_BYTE, LBLS_DEV_32, 32'h10 + 32'(o), 32'h0, 0);
            check("b be", 32'(got_be), 32'h8 >> o);
            check("b ld", got_v, {24'h0, b});
        end
        for (int o = 0; o < 4; o += 2) begin
            b = 8'h11 + 8'(o);
            acc(0, LBLS_SZ_HALF, LBLS_DEV_16, 32'h10 + 32'(o), 32'h0, 0);
            check("h be", 32'(got_be), o ? 32'h3 : 32'hc);
            check("h ld", got_v, {16'h0, b, b + 8'h1});
        end
        $display("narrow load test done");
    endtask

    // byte stores to an 8-bit device, half stores to a 16-bit and a 32-bit one
    task automatic t_store();
        logic [7:0] b;
        wait_n <= 4'h1;
        for (int o = 0; o < 4; o++) begin
            b = 8'ha0 + 8'(o);
            acc(1, LBLS_SZ_BYTE, LBLS_DEV_8, 32'h20 + 32'(o),
                {24'h5a5a5a, b}, 0);
            check("bs be", 32'(got_be), 32'h8 >> o);
            check("bs lane", got_v, {24'h0, b} << (8 * (3 - o)));
        end
        acc(0, LBLS_SZ_WORD, LBLS_DEV_32, 32'h20, 32'h0, 0);
        check("bs mem", got_v, 32'ha0a1a2a3);
        acc(1, LBLS_SZ_HALF, LBLS_DEV_16, 32'h24, 32'hffffb1b2, 0);
        check("hs0 be", 32'(got_be), 32'hc);
        check("hs0 lane", got_v, 32'hb1b20000);
        acc(1, LBLS_SZ_HALF, LBLS_DEV_32, 32'h26, 32'heeeec1c2, 0);
        check("hs2 be", 32'(got_be), 32'h3);
        check("hs2 lane", got_v, 32'h0000c1c2);
        acc(0, LBLS_SZ_WORD, LBLS_DEV_32, 32'h24, 32'h0, 0);
        check("hs mem", got_v, 32'hb1b2c1c2);
        $display("store test done");
    endtask

    // misaligned, oversize and bad codes: no bus cycle, memory kept
    task automatic t_refuse();
        logic [1:0] sz [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h3};
        logic [1:0] dv [7] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2};
        logic [7:0] lo [7] = '{8'h11, 8'h13, 8'h12, 8'h10, 8'h10, 8'h10,
                               8'h10};
        wait_n <= 4'h0;
        for (int i = 0; i < 7; i++) begin
            acc(1, sz[i], dv[i], {24'h0, lo[i]}, 32'hdeadbeef, 1);
        end
        acc(0, LBLS_SZ_WORD, LBLS_DEV_32, 32'h10, 32'h0, 0);
        check("kept", got_v, 32'h11121314);
        $display("refusal test done");
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge CLK);
        t_word();
        t_narrow_ld();
        t_store();
        t_refuse();
        finish_test();
    end
endmodule
`default_nettype wire
